// ===== core/smps_seq_pkg.sv
// Constants and types shared by the enable sequencer
package smps_seq_pkg;
  localparam int unsigned CLK_FREQ_HZ  = 125000000;
  localparam int unsigned SOFT_START_US = 1500;
  localparam int unsigned PG_DELAY_US   = 1250;
  localparam int unsigned DEAD_TIME_NS  = 21;
  localparam int unsigned SOFT_START_CYC = SOFT_START_US * (CLK_FREQ_HZ / 1000000);
  localparam int unsigned PG_DELAY_CYC   = PG_DELAY_US * (CLK_FREQ_HZ / 1000000);
  localparam int unsigned DEAD_TIME_CYC  = (DEAD_TIME_NS * (CLK_FREQ_HZ / 1000000) + 999) / 1000;
  localparam int unsigned CNT_W  = 20;
  localparam int unsigned REF_W  = 10;
  localparam logic [9:0] REF_FINAL = 10'h258;
  localparam logic [7:0] DEAD_W_CYC = 8'(DEAD_TIME_CYC);
  localparam logic [7:0] IRQ_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [11:0] ADDR_CTRL   = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_IRQ    = 12'h008;
  localparam logic [11:0] ADDR_MASK   = 12'h00C;
  localparam logic [11:0] ADDR_REF    = 12'h010;
  localparam int unsigned IRQ_REG1 = 0;
  localparam int unsigned IRQ_REG2 = 1;
  localparam int unsigned IRQ_PG   = 2;
  localparam int unsigned IRQ_FAULT = 3;
  localparam int unsigned IRQ_SHUT = 4;
  typedef enum logic [1:0] {LVL_LOW, LVL_FLOAT, LVL_HIGH} enable_level_t;
  typedef enum logic [2:0] {CH_OFF, CH_WAIT, CH_RAMP, CH_DELAY, CH_GOOD} ch_state_t;
endpackage

// ===== core/dual_smps_enable_sequencer.sv
// Enable decoding, soft-start, power-good and dead-time logic of a dual switcher
// Notes on behaviour
// R1: Everything stays off until input supply is above its power-on-reset level.
// R2: Gate-drive supply below 4.2V shuts both switchers down.
// R3: A rising channel enable starts the soft-start delay and output ramp.
// R4: Reference ramps from zero to 0.6V over about 1.5ms.
// R5: Power good released 1.25ms after reference reaches 0.6V, if no fault.
// R6: Any fault turns on the power-good pull-down.
// R7: Gate-drive regulator stays off until some enable is high.
// R8: No soft-start before gate-drive supply is above 4.2V.
// R9: Low with low or floating, or both floating, keeps both switchers off.
// R10: First floating, second high: second starts, first follows its regulation.
// R11: First high, second floating: first starts, second follows its regulation.
// R12: Both high start together; high with low runs only the high one.
// R13: Internal supply switches to gate-drive supply above 4.2V.
// R14: A gate drive turns on only after the opposite has fallen, plus dead time.
// R15: High enables at once, floating defers to the other, low disables.
// R16: Each enable decodes to low, float or high and is held stable.
`timescale 1ns/1ps
`default_nettype none
module dual_smps_enable_sequencer (
  input  wire logic        ref_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        input_supply_por_in,
  input  wire logic        gate_drive_supply_ok_in,
  input  wire logic        channel_one_enable_hi_in,
  input  wire logic        channel_one_enable_lo_in,
  input  wire logic        channel_two_enable_hi_in,
  input  wire logic        channel_two_enable_lo_in,
  input  wire logic        linear_reg_enable_in,
  input  wire logic [1:0]  fault_in,
  input  wire logic [1:0]  pwm_in,
  input  wire logic [1:0]  high_side_sense_in,
  input  wire logic [1:0]  low_side_sense_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic [31:0]      prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  output logic             irq_out,
  output logic             gate_drive_reg_on_out,
  output logic             supply_switchover_out,
  output logic [1:0]       switcher_on_out,
  output logic [9:0]       feedback_ref_one_out,
  output logic [9:0]       feedback_ref_two_out,
  output logic             power_good_out,
  output logic             power_good_oe_n_out,
  output logic [1:0]       high_side_drive_out,
  output logic [1:0]       low_side_drive_out
);
  import smps_seq_pkg::*;

  // Synchronise the fifteen supply, enable, fault, modulator and sense inputs through two flops
  localparam int unsigned NSYNC = 15;
  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] s1_q;
  logic [NSYNC-1:0] s2_q;
  assign raw_in = {low_side_sense_in, high_side_sense_in, pwm_in, fault_in,
                   linear_reg_enable_in, channel_two_enable_lo_in, channel_two_enable_hi_in,
                   channel_one_enable_lo_in, channel_one_enable_hi_in,
                   gate_drive_supply_ok_in, input_supply_por_in};
  always_ff @(posedge ref_clk_in) begin
    s1_q <= rst_n_in ? raw_in : '0;
    s2_q <= rst_n_in ? s1_q : '0;
  end
  wire       vin_ok  = s2_q[0];
  wire       gate_drive_supply_ok = s2_q[1];
  wire       ldo_en  = s2_q[6];
  wire [1:0] flt     = s2_q[8:7];
  wire [1:0] pwm     = s2_q[10:9];
  wire [1:0] hs_fb   = s2_q[12:11];
  wire [1:0] ls_fb   = s2_q[14:13];

  // Per-channel three-level decode, held two cycles before use
  enable_level_t lvl_raw [2];
  enable_level_t lvl_q   [2];
  enable_level_t lvl_p_q [2];
  enable_level_t lvl     [2];
  logic [1:0] en_hi;
  logic [1:0] en_fl;
  logic [1:0] ch_good;
  logic [1:0] go;
  logic [1:0] fault_q;
  logic       ctrl_sw_q;
  wire        run_ok = vin_ok & gate_drive_supply_ok & ctrl_sw_q; // [R1] [R2] [R8]

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_dec
      wire hi = s2_q[2 + 2*gi];
      wire lo = s2_q[3 + 2*gi];
      assign lvl_raw[gi] = hi ? LVL_HIGH : (lo ? LVL_LOW : LVL_FLOAT); // [R16]
      always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
          lvl_q[gi]   <= LVL_LOW;
          lvl_p_q[gi] <= LVL_LOW;
          lvl[gi]     <= LVL_LOW;
        end else begin
          lvl_q[gi] <= lvl_raw[gi];
          lvl_p_q[gi] <= lvl_q[gi];
          if (lvl_q[gi] == lvl_p_q[gi]) lvl[gi] <= lvl_p_q[gi]; // [R16]
        end
      end
      assign en_hi[gi] = (lvl[gi] == LVL_HIGH);
      assign en_fl[gi] = (lvl[gi] == LVL_FLOAT);
    end
  endgenerate

  // Truth-table start decisions; float waits on the other channel's regulation
  assign go[0] = en_hi[0] | (en_fl[0] & en_hi[1] & ch_good[1]); // [R9] [R10] [R12] [R15]
  assign go[1] = en_hi[1] | (en_fl[1] & en_hi[0] & ch_good[0]); // [R9] [R11] [R12] [R15]

  assign gate_drive_reg_on_out = vin_ok & (en_hi[0] | en_hi[1] | ldo_en); // [R7]
  assign supply_switchover_out = vin_ok & gate_drive_supply_ok;                        // [R13]

  ch_state_t        st_q  [2];
  logic [CNT_W-1:0] cnt_q [2];
  logic [REF_W-1:0] ref_q [2];
  logic [1:0]       ch_on;
  logic [1:0]       ramp_done_ev;
  logic [1:0]       dead_hs_ok;
  logic [1:0]       dead_ls_ok;
  logic [7:0]       irq_set;

  generate
    for (gi = 0; gi < 2; gi++) begin : g_ch
      // Reference steps once per cycle chunk so it reaches final value at ramp end
      localparam logic [CNT_W-1:0] STEP = CNT_W'(SOFT_START_CYC / REF_FINAL);
      wire ramp_tick = (cnt_q[gi] == STEP - 1'b1);
      always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
          st_q[gi] <= CH_OFF;
          cnt_q[gi] <= '0;
          ref_q[gi] <= '0;
          fault_q[gi] <= 1'b0;
        end else if (!run_ok || !go[gi]) begin
          st_q[gi] <= CH_OFF; // [R1] [R2] [R9]
          cnt_q[gi] <= '0;
          ref_q[gi] <= '0;
          if (!run_ok || lvl[gi] == LVL_LOW) fault_q[gi] <= 1'b0;
        end else begin
          if (flt[gi]) fault_q[gi] <= 1'b1;
          case (st_q[gi])
            CH_OFF: begin
              st_q[gi] <= fault_q[gi] ? CH_OFF : CH_RAMP; // [R3] [R8]
              cnt_q[gi] <= '0;
            end
            CH_RAMP: begin
              cnt_q[gi] <= ramp_tick ? '0 : cnt_q[gi] + 1'b1;
              if (ramp_tick) ref_q[gi] <= ref_q[gi] + 1'b1; // [R4]
              if (ramp_tick && ref_q[gi] == REF_FINAL - 1'b1) st_q[gi] <= CH_DELAY;
            end
            CH_DELAY: begin
              cnt_q[gi] <= cnt_q[gi] + 1'b1;
              if (cnt_q[gi] == CNT_W'(PG_DELAY_CYC - 1)) st_q[gi] <= CH_GOOD; // [R5]
            end
            CH_GOOD: cnt_q[gi] <= '0;
            default: st_q[gi] <= CH_OFF;
          endcase
        end
      end
      assign ch_on[gi]   = (st_q[gi] != CH_OFF) & ~fault_q[gi];
      assign ch_good[gi] = (st_q[gi] == CH_GOOD) & ~fault_q[gi];
      assign ramp_done_ev[gi] = (st_q[gi] == CH_RAMP) & ramp_tick & (ref_q[gi] == REF_FINAL - 1'b1);

      // Adaptive dead time: wait for opposite drive sensed low plus fixed cycles
      logic [7:0] dly_hs_q;
      logic [7:0] dly_ls_q;
      always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
          dly_hs_q <= '0;
          dly_ls_q <= '0;
          high_side_drive_out[gi] <= 1'b0;
          low_side_drive_out[gi] <= 1'b0;
        end else begin
          dly_hs_q <= (ls_fb[gi] || low_side_drive_out[gi]) ? '0 :
                      (dly_hs_q == DEAD_W_CYC ? dly_hs_q : dly_hs_q + 1'b1);
          dly_ls_q <= (hs_fb[gi] || high_side_drive_out[gi]) ? '0 :
                      (dly_ls_q == DEAD_W_CYC ? dly_ls_q : dly_ls_q + 1'b1);
          high_side_drive_out[gi] <= ch_on[gi] & pwm[gi] & dead_hs_ok[gi];  // [R14]
          low_side_drive_out[gi]  <= ch_on[gi] & ~pwm[gi] & dead_ls_ok[gi]; // [R14]
        end
      end
      // Gap must also cover the cycle in which the opposite drive is dropped
      assign dead_hs_ok[gi] = (dly_hs_q == DEAD_W_CYC) & ~low_side_drive_out[gi] &
                              ~ls_fb[gi];
      assign dead_ls_ok[gi] = (dly_ls_q == DEAD_W_CYC) & ~high_side_drive_out[gi] &
                              ~hs_fb[gi];
    end
  endgenerate

  assign switcher_on_out = ch_on;
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      feedback_ref_one_out <= '0;
      feedback_ref_two_out <= '0;
    end else begin
      feedback_ref_one_out <= ref_q[0];
      feedback_ref_two_out <= ref_q[1];
    end
  end

  // Power good: pull-down active unless some channel runs, every running one is good and no fault is latched
  wire any_fault = |fault_q;
  wire pg_ok = vin_ok & ~any_fault & (ch_on != 2'b00) &
               ((ch_good & ch_on) == ch_on); // [R5] [R6]
  logic pg_q;
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) pg_q <= 1'b0;
    else           pg_q <= pg_ok;
  end
  assign power_good_out      = 1'b0;
  assign power_good_oe_n_out = pg_q; // [R6]

  // Register bus and interrupts
  logic [7:0] irq_q;
  logic [7:0] mask_q;
  logic       pg_prev_q;
  logic       run_prev_q;
  logic [1:0] fault_prev_q;
  wire        acc    = psel_in & penable_in;
  wire        wr     = acc & pwrite_in;
  wire        rd_irq = acc & ~pwrite_in & (paddr_in == ADDR_IRQ);
  wire        hit    = (paddr_in == ADDR_CTRL) | (paddr_in == ADDR_STATUS) |
                       (paddr_in == ADDR_IRQ) | (paddr_in == ADDR_MASK) |
                       (paddr_in == ADDR_REF);
  assign irq_set = {3'b000, run_prev_q & ~run_ok, |(fault_q & ~fault_prev_q), pg_q & ~pg_prev_q,
                    ramp_done_ev[1], ramp_done_ev[0]};
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      irq_q <= IRQ_RESET;
      mask_q <= MASK_RESET;
      ctrl_sw_q <= 1'b1;
      pg_prev_q <= 1'b0;
      run_prev_q <= 1'b0;
      fault_prev_q <= 2'b00;
    end else begin
      pg_prev_q <= pg_q;
      run_prev_q <= run_ok;
      fault_prev_q <= fault_q;
      // A read clears only the bits it reported, so a later event survives
      irq_q <= (rd_irq ? (irq_q & ~prdata_out[7:0]) : irq_q) | irq_set;
      if (wr && paddr_in == ADDR_MASK) mask_q <= pwdata_in[7:0];
      if (wr && paddr_in == ADDR_CTRL) ctrl_sw_q <= pwdata_in[0];
    end
  end
  assign irq_out = |(irq_q & mask_q);

  wire [31:0] rd_mux =
    (paddr_in == ADDR_CTRL)   ? {31'h0, ctrl_sw_q} :
    (paddr_in == ADDR_STATUS) ? {20'h0, 3'(st_q[1]), 3'(st_q[0]), fault_q, pg_q, run_ok,
                                 gate_drive_reg_on_out, supply_switchover_out} :
    (paddr_in == ADDR_IRQ)    ? {24'h0, irq_q} :
    (paddr_in == ADDR_MASK)   ? {24'h0, mask_q} :
    (paddr_in == ADDR_REF)    ? {6'h0, ref_q[1], 6'h0, ref_q[0]} : 32'h0;
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) prdata_out <= '0;
    else if (psel_in && !penable_in && !pwrite_in) prdata_out <= rd_mux;
  end
  assign pready_out  = 1'b1;
  assign pslverr_out = acc & ~hit;

  // Soft-start on channel one ends only if the channel was already ramping two cycles before
  property ramp_len_p;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      $rose(ramp_done_ev[0]) |-> $past(st_q[0] == CH_RAMP, 2);
  endproperty
  ramp_reaches_final_a: assert property (ramp_len_p) // [R4]
    else $error("ramp ended early");
  pg_fault_low_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      any_fault |=> !power_good_oe_n_out) // [R6]
    else $error("power good released under fault");
  shut_on_gate_drive_supply_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      !gate_drive_supply_ok |=> switcher_on_out == 2'b00) // [R2]
    else $error("switcher on without gate supply");
  off_no_vin_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      !vin_ok |-> !gate_drive_reg_on_out ##1 (switcher_on_out == 2'b00)) // [R1]
    else $error("active without input supply");
  no_overlap_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      !(high_side_drive_out[0] && low_side_drive_out[0])) // [R14]
    else $error("shoot-through on channel one");
  float_waits_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      (en_fl[0] && !ch_good[1]) |=> !switcher_on_out[0]) // [R10]
    else $error("float channel started early");
  float_two_waits_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      (en_fl[1] && !ch_good[0]) |=> !switcher_on_out[1]) // [R11]
    else $error("float channel two started early");
  gate_reg_hold_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      (!en_hi[0] && !en_hi[1] && !ldo_en) |-> !gate_drive_reg_on_out) // [R7]
    else $error("gate regulator on without enable");
  no_overlap_two_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      !(high_side_drive_out[1] && low_side_drive_out[1])) // [R14]
    else $error("shoot-through on channel two");
  // Each drive of channel one turns on only after the opposite one has been off a full gap
  high_dead_gap_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      $rose(high_side_drive_out[0]) |-> !low_side_drive_out[0] &&
      $past(!low_side_drive_out[0], 1) && $past(!low_side_drive_out[0], 2) &&
      $past(!low_side_drive_out[0], 3)) // [R14]
    else $error("high drive on inside dead time");
  low_dead_gap_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      $rose(low_side_drive_out[0]) |-> !high_side_drive_out[0] &&
      $past(!high_side_drive_out[0], 1) && $past(!high_side_drive_out[0], 2) &&
      $past(!high_side_drive_out[0], 3)) // [R14]
    else $error("low drive on inside dead time");
endmodule // dual_smps_enable_sequencer
`default_nettype wire

// ===== verif/power_stage_model.sv
// Behavioural gate-sense model of the external power stage, both channels
`timescale 1ns/1ps
`default_nettype none
module power_stage_model (
  input  wire logic       ref_clk_in,
  input  wire logic [1:0] high_drive_in,
  input  wire logic [1:0] low_drive_in,
  input  wire logic [2:0] fall_cyc_in,
  output logic [1:0]      high_sense_out,
  output logic [1:0]      low_sense_out
);
  int hcnt [2];
  int lcnt [2];
  // Gate voltage stays above 1V for fall_cyc_in cycles after the drive drops
  always @(posedge ref_clk_in) begin
    for (int i = 0; i < 2; i++) begin
      hcnt[i] = high_drive_in[i] ? int'(fall_cyc_in) : (hcnt[i] > 0 ? hcnt[i] - 1 : 0);
      lcnt[i] = low_drive_in[i] ? int'(fall_cyc_in) : (lcnt[i] > 0 ? lcnt[i] - 1 : 0);
      high_sense_out[i] <= high_drive_in[i] || hcnt[i] > 0;
      low_sense_out[i]  <= low_drive_in[i] || lcnt[i] > 0;
    end
  end
endmodule // power_stage_model
`default_nettype wire

// ===== verif/tb_top.sv
// Self-checking bench of the dual switcher enable sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import smps_seq_pkg::*;
  logic        clk, rst_n, por, gok, e1h, e1l, e2h, e2l, lin, psel, pen, pwr;
  logic [1:0]  flt, pwm, hs, ls, son, hd, ld, hd_q;
  logic [11:0] pa;
  logic [31:0] pwd, prd, rd;
  logic [9:0]  r1, r2;
  logic [2:0]  fall;
  logic        prdy, perr, irq, gdr, sw, pg, pg_oe_n, er;
  int          bad_count, n_checks, n_rise;
  dual_smps_enable_sequencer i_dut (.ref_clk_in(clk), .rst_n_in(rst_n),
    .input_supply_por_in(por), .gate_drive_supply_ok_in(gok),
    .channel_one_enable_hi_in(e1h), .channel_one_enable_lo_in(e1l),
    .channel_two_enable_hi_in(e2h), .channel_two_enable_lo_in(e2l),
    .linear_reg_enable_in(lin), .fault_in(flt), .pwm_in(pwm),
    .high_side_sense_in(hs), .low_side_sense_in(ls), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd), .prdata_out(prd), .pready_out(prdy),
    .pslverr_out(perr), .irq_out(irq), .gate_drive_reg_on_out(gdr),
    .supply_switchover_out(sw), .switcher_on_out(son), .feedback_ref_one_out(r1),
    .feedback_ref_two_out(r2), .power_good_out(pg), .power_good_oe_n_out(pg_oe_n),
    .high_side_drive_out(hd), .low_side_drive_out(ld));
  power_stage_model i_stage (.ref_clk_in(clk), .high_drive_in(hd), .low_drive_in(ld),
    .fall_cyc_in(fall), .high_sense_out(hs), .low_sense_out(ls));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic end_of_test();
    if (bad_count == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    int n;
    @(posedge clk);
    psel <= 1'b1; pen <= 1'b0; pwr <= w; pa <= a; pwd <= wd;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (prdy !== 1'b1 && n < 20);
    if (prdy !== 1'b1) begin
      bad_count++;
      end_of_test();
    end
    rd = prd; er = perr;
    psel <= 1'b0; pen <= 1'b0;
  endtask
  task automatic set_en(input enable_level_t l1, input enable_level_t l2);
    e1h <= (l1 == LVL_HIGH); e1l <= (l1 == LVL_LOW);
    e2h <= (l2 == LVL_HIGH); e2l <= (l2 == LVL_LOW);
    repeat (10) @(posedge clk);
  endtask
  // Start-up decision for one pair of decoded enables, bit0 is switcher one
  function automatic logic [1:0] exp_on(enable_level_t l1, enable_level_t l2);
    exp_on[0] = (l1 == LVL_HIGH);
    exp_on[1] = (l2 == LVL_HIGH);
  endfunction
  // Shoot-through watch on the gate drives
  always @(posedge clk) begin
    hd_q <= hd;
    for (int i = 0; i < 2; i++) begin
      if (hd[i] && ld[i]) chk("both drives", 1, 0);
      if (hd[i] && !hd_q[i]) chk("low sense at high on", ls[i], 0);
      if (hd[i] && !hd_q[i]) n_rise++;
    end
  end
  initial begin
    enable_level_t lv [3];
    lv = '{LVL_LOW, LVL_FLOAT, LVL_HIGH};
    bad_count = 0; n_checks = 0; rd = $urandom(17);
    rst_n = 0; por = 1; gok = 1; e1h = 0; e1l = 1; e2h = 0; e2l = 1; lin = 0;
    flt = 0; pwm = 0; psel = 0; pen = 0; pwr = 0; pa = 0; pwd = 0;
    fall = 3'($urandom_range(1, 5));
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (10) @(posedge clk);
    chk("gate reg idle", gdr, 0);
    apb(0, ADDR_MASK, 0); chk("mask reset", rd, 32'(MASK_RESET));
    apb(1, ADDR_MASK, 32'h00000018); apb(0, ADDR_MASK, 0); chk("mask", rd, 32'h00000018);
    apb(0, 12'hFFC, 0); chk("unmapped err", er, 1); chk("unmapped data", rd, 0);
    apb(0, ADDR_CTRL, 0);
    chk("ctrl reset", rd, 32'h00000001);
    foreach (lv[a]) foreach (lv[b]) begin
      lin <= 1'($urandom);
      set_en(lv[a], lv[b]);
      chk("switcher on", son, exp_on(lv[a], lv[b]));
      chk("gate reg", gdr, (lv[a] == LVL_HIGH) || (lv[b] == LVL_HIGH) || lin);
      lin <= 1'b0;
      set_en(LVL_LOW, LVL_LOW);
    end
    set_en(LVL_HIGH, LVL_HIGH);
    // Hold each modulator command long enough for the dead-time gap to expire
    repeat (50) begin
      pwm <= 2'($urandom);
      repeat (20) @(posedge clk);
    end
    chk("drive activity", n_rise > 0, 1);
    chk("ramp started", r1 > 0 && r1 <= 10'h004, 1);
    chk("ramps together", r1, r2);
    chk("pg held", pg_oe_n, 0);
    flt <= 2'h1;
    repeat (10) @(posedge clk);
    chk("fault off", son, 2'h2);
    chk("fault pg", pg_oe_n, 0);
    chk("irq up", irq, 1);
    apb(0, ADDR_IRQ, 0); chk("fault flag", rd[IRQ_FAULT], 1);
    apb(0, ADDR_IRQ, 0); chk("flag cleared", rd[IRQ_FAULT], 0);
    chk("irq down", irq, 0);
    flt <= 2'h0;
    set_en(LVL_LOW, LVL_HIGH);
    set_en(LVL_HIGH, LVL_HIGH);
    chk("fault release", son, 2'h3);
    gok <= 1'b0;
    repeat (10) @(posedge clk);
    chk("gate loss", son, 0);
    chk("no switchover", sw, 0);
    chk("ref held", r1, 0);
    apb(0, ADDR_IRQ, 0); chk("shutdown flag", rd[IRQ_SHUT], 1);
    gok <= 1'b1;
    repeat (10) @(posedge clk);
    chk("switchover", sw, 1);
    por <= 1'b0;
    repeat (10) @(posedge clk);
    chk("input supply loss", son, 0);
    end_of_test();
  end
endmodule // tb_top
`default_nettype wire
